/* File: tac_pkg.sv */
// Package of constants for the T1 alarm and overhead control block
`default_nettype none
package tac_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] EVENT_STATUS_REG_ONE_OFS  = 12'h0_000;
    localparam logic [11:0] EVENT_MASK_REG_ONE_OFS    = 12'h0_004;
    localparam logic [11:0] EVENT_STATUS_REG_FOUR_OFS = 12'h0_008;
    localparam logic [11:0] EVENT_MASK_REG_FOUR_OFS   = 12'h0_00C;
    localparam logic [11:0] IRQ_SOURCE_INFO_ONE_OFS   = 12'h0_010;
    localparam logic [11:0] IRQ_SOURCE_INFO_TWO_OFS   = 12'h0_014;
    localparam logic [11:0] COMMON_CTRL_THREE_OFS     = 12'h0_018;
    localparam logic [11:0] TX_CTRL_ONE_OFS           = 12'h0_01C;
    localparam logic [11:0] TX_CTRL_TWO_OFS           = 12'h0_020;
    localparam logic [11:0] RX_CTRL_TWO_OFS           = 12'h0_024;
    localparam logic [11:0] FRAMER_COMMON_CTRL_OFS    = 12'h0_028;
    localparam logic [11:0] SIG_INSERT_ENABLE_OFS     = 12'h0_02C;
    localparam logic [11:0] CLEAR_CHANNEL_OFS         = 12'h0_030;
    localparam logic [11:0] RX_MILLIWATT_SELECT_OFS   = 12'h0_034;
    localparam logic [11:0] RX_BOC_CODE_OFS           = 12'h0_038;
    localparam logic [11:0] ALARM_LIVE_OFS            = 12'h0_03C;
    localparam logic [11:0] TX_SIGNALLING_REG_OFS     = 12'h0_040;
    localparam int          SIG_WORDS                 = 3;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int IRQ_PIN_DISABLE_BIT = 6;  // common_ctrl_three
    localparam int SEND_BLUE_ALARM_BIT = 0;  // tx_ctrl_one
    localparam int SEND_YELLOW_BIT     = 1;  // tx_ctrl_one
    localparam int STUFF_ALL_A_BIT     = 3;  // tx_ctrl_one
    localparam int STUFF_ALL_B_BIT     = 0;  // tx_ctrl_two
    localparam int TX_ESF_BIT          = 1;  // tx_ctrl_two
    localparam int YEL_F12_MODE_BIT    = 0;  // rx_ctrl_two
    localparam int RX_ESF_BIT          = 1;  // rx_ctrl_two
    localparam int SEND_AIS_CI_BIT     = 0;  // framer_common_ctrl
    localparam int SEND_RAI_CI_BIT     = 1;  // framer_common_ctrl
    // event_status_reg_one bits
    localparam int RX_BLUE_ALARM_BIT   = 0;
    localparam int RX_YELLOW_ALARM_BIT = 1;
    localparam int RX_CARRIER_LOSS_BIT = 2;
    localparam int RX_FRAME_LOSS_BIT   = 3;
    // event_status_reg_four bits
    localparam int GOT_AIS_CI_BIT      = 0;
    localparam int GOT_BOC_BIT         = 1;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam int          CHANNELS         = 24;
    localparam int          BLUE_WIN_MS      = 3;
    localparam int          T1_BITS_PER_MS   = 1544;
    localparam int          BLUE_WIN_BITS    = BLUE_WIN_MS * T1_BITS_PER_MS;
    localparam logic [2:0]  BLUE_SET_MAX     = 3'h5;
    localparam logic [8:0]  RED_SET_ZEROS    = 9'h0_0C0;
    localparam logic [6:0]  RED_WIN_LAST     = 7'h6F;
    localparam logic [3:0]  RED_CLR_ONES     = 4'hE;
    localparam logic [7:0]  Y2_WIN_LAST      = 8'hFF;
    localparam logic [8:0]  Y2_SET_ZEROS     = 9'h0_0FE;
    localparam logic [15:0] FDL_YEL_PATTERN  = 16'h00FF;
    localparam logic [4:0]  FDL_SET_RUN      = 5'h10;
    localparam logic [4:0]  FDL_CLR_MAX      = 5'h0E;
    localparam logic [5:0]  BOC_RAI_CI       = 6'h1F;

    // Digital-milliwatt byte sequence
    localparam logic [63:0] MILLIWATT_SEQ    = 64'h1E0B_0B1E_9E8B_8B9E;
endpackage
`default_nettype wire

/* File: tac_alarm_ovh.sv */
// T1 alarm detection, overhead insertion and event reporting with APB registers
//
// Decided for this implementation: register access over APB and the register addresses.
`default_nettype none

// Notes on behaviour
// - Each status register has a mask; a bit interrupts only when masked in.
// - All writable registers, masks included, clear to zero at reset.
// - Two source-info registers show which status registers interrupt.
// - Bit 6 of common control three silences the interrupt output while set.
// - Enabled channels take robbed signalling bits from host signalling registers.
// - Clear channels get no robbed-bit signalling, and no bit 7 stuffing unless both global stuffing bits are set.
// - D4 yellow transmission forces bit 2 to zero, clear channels too.
// - Both global stuffing bits set stuff bit 7 on all 24 channels.
// - AIS-CI sent when AIS-CI and blue bits both set, same in ESF and D4.
// - Recognised incoming AIS-CI sets a flag in status register four.
// - ESF RAI-CI bit sends RAI-CI, seen by receivers as yellow alarm.
// - Received 6-bit BOC message is reported; 011111 marks RAI-CI.
// - Milliwatt-selected channels get the 8-byte 1E/0B/0B/1E/9E/8B/8B/9E pattern.
// - Blue sets at five or fewer zeros per 3ms, clears at six or more.
// - D4 bit-2 yellow sets at 254 of 256 zeros, clears below 254.
// - 12th F-bit yellow sets on two ones, clears on two zeros.
// - ESF yellow sets on 16 consecutive 00FF, clears at 14 or fewer of 16.
// - Red sets after 192 zeros, clears on 14 ones in 112 bits.
// - Blue detection tolerates 10E-3 errors and ignores framed all-ones.
module tac_alarm_ovh #(
    parameter int BLUE_WIN = tac_pkg::BLUE_WIN_BITS
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Receive line bit stream and framer indications
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    input  wire logic        rx_fbit_valid,
    input  wire logic        rx_fbit_twelfth,
    input  wire logic        rx_fbit,
    input  wire logic        rx_fdl_valid,
    input  wire logic        rx_fdl_bit,
    input  wire logic        rx_ais_ci_detect,
    input  wire logic        rx_boc_valid,
    input  wire logic [5:0]  rx_boc,
    input  wire logic        rx_frame_loss,
    // Receive channel bytes toward the backplane
    input  wire logic        rx_ch_valid,
    input  wire logic [4:0]  rx_ch_num,
    input  wire logic [7:0]  rx_ch_data,
    output logic             bp_valid,
    output logic      [7:0]  bp_data,
    // Transmit channel bytes toward the line
    input  wire logic        tx_ch_valid,
    input  wire logic [4:0]  tx_ch_num,
    input  wire logic [7:0]  tx_ch_data,
    input  wire logic        tx_rob_frame,
    input  wire logic [1:0]  tx_sig_sel,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    output logic             tx_ais_ci_on,
    output logic             tx_rai_ci_on,
    // Interrupt
    output logic             irq
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  sr1;
        logic [1:0]  sr4;
        logic [3:0]  m1;
        logic [1:0]  m4;
        logic [7:0]  ccr3;
        logic [7:0]  txc1;
        logic [7:0]  txc2;
        logic [7:0]  rxc2;
        logic [7:0]  fcc;
        logic [23:0] sig_en;
        logic [23:0] clr_ch;
        logic [23:0] mw_sel;
        logic [95:0] sig;
        logic [5:0]  boc;
        logic        blue;
        logic        yel;
        logic        red;
        logic [12:0] blue_cnt;
        logic [2:0]  blue_zeros;
        logic [8:0]  red_run;
        logic [6:0]  red_win;
        logic [3:0]  red_ones;
        logic [7:0]  y2_cnt;
        logic [8:0]  y2_zeros;
        logic        f12_prev;
        logic [15:0] fdl_sh;
        logic [3:0]  fdl_bits;
        logic [4:0]  fdl_run;
        logic [3:0]  fdl_pat;
        logic [4:0]  fdl_hit;
        logic [2:0]  mw_idx;
        logic        tx_valid;
        logic [7:0]  tx_data;
        logic        tx_ais_ci_on;
        logic        tx_rai_ci_on;
        logic        bp_valid;
        logic [7:0]  bp_data;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tac_state_t;

    localparam logic [12:0] BLUE_LAST = 13'(BLUE_WIN - 1);

    tac_state_t st;
    tac_state_t next_st;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Working values are declared first and set at the top of the process
    always_comb
    begin
        logic        wr;
        logic        rd_go;
        logic        hit;
        logic [31:0] rdv;
        logic [3:0]  live1;
        logic [3:0]  set1;
        logic [1:0]  set4;
        logic [3:0]  clr1;
        logic [1:0]  clr4;
        logic [2:0]  bz;
        logic [3:0]  ro;
        logic [8:0]  yz;
        logic [15:0] fsh;
        logic        fmatch;
        logic [4:0]  frun;
        logic [4:0]  fhit;
        logic [7:0]  tb;
        logic        stuff;
        logic        rob;
        logic [6:0]  sidx;
        logic        info1;
        logic        info4;
        wr     = 1'b0;
        rd_go  = 1'b0;
        hit    = 1'b1;
        rdv    = 32'h0000_0000;
        live1  = 4'h0;
        set1   = 4'h0;
        set4   = 2'h0;
        clr1   = 4'h0;
        clr4   = 2'h0;
        bz     = 3'h0;
        ro     = 4'h0;
        yz     = 9'h0_000;
        fsh    = 16'h0000;
        fmatch = 1'b0;
        frun   = 5'h00;
        fhit   = 5'h00;
        tb     = 8'h00;
        stuff  = 1'b0;
        rob    = 1'b0;
        sidx   = 7'h00;
        info1  = 1'b0;
        info4  = 1'b0;
        next_st = st;

        // APB: one wait state, then pready for exactly one cycle
        next_st.pready  = psel && penable && !st.pready;
        next_st.pslverr = 1'b0;
        wr    = psel && penable && st.pready && pwrite;
        rd_go = psel && penable && !st.pready && !pwrite;

        info1 = |(st.sr1 & st.m1);
        info4 = |(st.sr4 & st.m4);

        // Address decode for reads and unmapped detection
        if (paddr == tac_pkg::EVENT_STATUS_REG_ONE_OFS)
            rdv = {28'h000_0000, st.sr1};
        else if (paddr == tac_pkg::EVENT_MASK_REG_ONE_OFS)
            rdv = {28'h000_0000, st.m1};
        else if (paddr == tac_pkg::EVENT_STATUS_REG_FOUR_OFS)
            rdv = {30'h0000_0000, st.sr4};
        else if (paddr == tac_pkg::EVENT_MASK_REG_FOUR_OFS)
            rdv = {30'h0000_0000, st.m4};
        else if (paddr == tac_pkg::IRQ_SOURCE_INFO_ONE_OFS)
            rdv = {31'h0000_0000, info1};
        else if (paddr == tac_pkg::IRQ_SOURCE_INFO_TWO_OFS)
            rdv = {31'h0000_0000, info4};
        else if (paddr == tac_pkg::COMMON_CTRL_THREE_OFS)
            rdv = {24'h00_0000, st.ccr3};
        else if (paddr == tac_pkg::TX_CTRL_ONE_OFS)
            rdv = {24'h00_0000, st.txc1};
        else if (paddr == tac_pkg::TX_CTRL_TWO_OFS)
            rdv = {24'h00_0000, st.txc2};
        else if (paddr == tac_pkg::RX_CTRL_TWO_OFS)
            rdv = {24'h00_0000, st.rxc2};
        else if (paddr == tac_pkg::FRAMER_COMMON_CTRL_OFS)
            rdv = {24'h00_0000, st.fcc};
        else if (paddr == tac_pkg::SIG_INSERT_ENABLE_OFS)
            rdv = {8'h00, st.sig_en};
        else if (paddr == tac_pkg::CLEAR_CHANNEL_OFS)
            rdv = {8'h00, st.clr_ch};
        else if (paddr == tac_pkg::RX_MILLIWATT_SELECT_OFS)
            rdv = {8'h00, st.mw_sel};
        else if (paddr == tac_pkg::RX_BOC_CODE_OFS)
            rdv = {26'h000_0000, st.boc};
        else if (paddr == tac_pkg::ALARM_LIVE_OFS)
            rdv = {28'h000_0000, rx_frame_loss, st.red, st.yel, st.blue};
        else if (paddr == tac_pkg::TX_SIGNALLING_REG_OFS)
            rdv = st.sig[31:0];
        else if (paddr == tac_pkg::TX_SIGNALLING_REG_OFS + 12'h0_004)
            rdv = st.sig[63:32];
        else if (paddr == tac_pkg::TX_SIGNALLING_REG_OFS + 12'h0_008)
            rdv = st.sig[95:64];
        else
            hit = 1'b0;
        if (rd_go)
            next_st.prdata = hit ? rdv : 32'h0000_0000;
        if (psel && penable && !st.pready)
            next_st.pslverr = !hit;

        // Register writes, taken on the edge where pready is high
        if (wr)
        begin
            if (paddr == tac_pkg::EVENT_STATUS_REG_ONE_OFS)
                clr1 = pwdata[3:0];
            else if (paddr == tac_pkg::EVENT_MASK_REG_ONE_OFS)
                next_st.m1 = pwdata[3:0];
            else if (paddr == tac_pkg::EVENT_STATUS_REG_FOUR_OFS)
                clr4 = pwdata[1:0];
            else if (paddr == tac_pkg::EVENT_MASK_REG_FOUR_OFS)
                next_st.m4 = pwdata[1:0];
            else if (paddr == tac_pkg::COMMON_CTRL_THREE_OFS)
                next_st.ccr3 = pwdata[7:0];
            else if (paddr == tac_pkg::TX_CTRL_ONE_OFS)
                next_st.txc1 = pwdata[7:0];
            else if (paddr == tac_pkg::TX_CTRL_TWO_OFS)
                next_st.txc2 = pwdata[7:0];
            else if (paddr == tac_pkg::RX_CTRL_TWO_OFS)
                next_st.rxc2 = pwdata[7:0];
            else if (paddr == tac_pkg::FRAMER_COMMON_CTRL_OFS)
                next_st.fcc = pwdata[7:0];
            else if (paddr == tac_pkg::SIG_INSERT_ENABLE_OFS)
                next_st.sig_en = pwdata[23:0];
            else if (paddr == tac_pkg::CLEAR_CHANNEL_OFS)
                next_st.clr_ch = pwdata[23:0];
            else if (paddr == tac_pkg::RX_MILLIWATT_SELECT_OFS)
                next_st.mw_sel = pwdata[23:0];
            else if (paddr == tac_pkg::TX_SIGNALLING_REG_OFS)
                next_st.sig[31:0] = pwdata;
            else if (paddr == tac_pkg::TX_SIGNALLING_REG_OFS + 12'h0_004)
                next_st.sig[63:32] = pwdata;
            else if (paddr == tac_pkg::TX_SIGNALLING_REG_OFS + 12'h0_008)
                next_st.sig[95:64] = pwdata;
        end

        // Blue alarm: zeros counted per fixed window; framing bits of a framed
        // all-ones signal add enough zeros to keep it from tripping
        if (rx_bit_valid)
        begin
            bz = st.blue_zeros;
            if (!rx_bit && bz != 3'h6)
                bz = bz + 3'h1;
            if (st.blue_cnt == BLUE_LAST)
            begin
                next_st.blue       = (bz <= tac_pkg::BLUE_SET_MAX);
                next_st.blue_cnt   = 13'h0000;
                next_st.blue_zeros = 3'h0;
            end
            else
            begin
                next_st.blue_cnt   = st.blue_cnt + 13'h0001;
                next_st.blue_zeros = bz;
            end
        end

        // Red alarm: run of zeros to set, ones in a 112-bit window to clear
        if (rx_bit_valid)
        begin
            if (rx_bit)
                next_st.red_run = 9'h0_000;
            else if (st.red_run != tac_pkg::RED_SET_ZEROS)
                next_st.red_run = st.red_run + 9'h0_001;
            if (!rx_bit && st.red_run == tac_pkg::RED_SET_ZEROS - 9'h0_001)
                next_st.red = 1'b1;
            if (st.red)
            begin
                ro = st.red_ones;
                if (rx_bit)
                    ro = ro + 4'h1;
                if (ro == tac_pkg::RED_CLR_ONES)
                begin
                    next_st.red      = 1'b0;
                    next_st.red_win  = 7'h00;
                    next_st.red_ones = 4'h0;
                end
                else if (st.red_win == tac_pkg::RED_WIN_LAST)
                begin
                    next_st.red_win  = 7'h00;
                    next_st.red_ones = 4'h0;
                end
                else
                begin
                    next_st.red_win  = st.red_win + 7'h01;
                    next_st.red_ones = ro;
                end
            end
        end

        // Yellow alarm, detector chosen by receive mode
        if (st.rxc2[tac_pkg::RX_ESF_BIT])
        begin
            if (rx_fdl_valid)
            begin
                fsh            = {st.fdl_sh[14:0], rx_fdl_bit};
                next_st.fdl_sh = fsh;
                next_st.fdl_bits = st.fdl_bits + 4'h1;
                if (st.fdl_bits == 4'hF)
                begin
                    fmatch = (fsh == tac_pkg::FDL_YEL_PATTERN);
                    frun   = fmatch ? ((st.fdl_run == tac_pkg::FDL_SET_RUN) ?
                             st.fdl_run : st.fdl_run + 5'h01) : 5'h00;
                    fhit   = st.fdl_hit + {4'h0, fmatch};
                    next_st.fdl_run = frun;
                    next_st.fdl_pat = st.fdl_pat + 4'h1;
                    next_st.fdl_hit = fhit;
                    if (frun == tac_pkg::FDL_SET_RUN)
                        next_st.yel = 1'b1;
                    if (st.fdl_pat == 4'hF)
                    begin
                        next_st.fdl_hit = 5'h00;
                        if (fhit <= tac_pkg::FDL_CLR_MAX)
                            next_st.yel = 1'b0;
                    end
                end
            end
        end
        else if (st.rxc2[tac_pkg::YEL_F12_MODE_BIT])
        begin
            if (rx_fbit_valid && rx_fbit_twelfth)
            begin
                next_st.f12_prev = rx_fbit;
                if (rx_fbit && st.f12_prev)
                    next_st.yel = 1'b1;
                else if (!rx_fbit && !st.f12_prev)
                    next_st.yel = 1'b0;
            end
        end
        else if (rx_ch_valid)
        begin
            yz = st.y2_zeros + {8'h00, !rx_ch_data[6]};
            next_st.y2_cnt = st.y2_cnt + 8'h01;
            if (st.y2_cnt == tac_pkg::Y2_WIN_LAST)
            begin
                next_st.yel      = (yz >= tac_pkg::Y2_SET_ZEROS);
                next_st.y2_zeros = 9'h0_000;
            end
            else
                next_st.y2_zeros = yz;
        end

        if (rx_boc_valid)
            next_st.boc = rx_boc;

        // Sticky status: a new event in the clearing cycle wins over the clear
        live1 = {rx_frame_loss, st.red, st.yel, st.blue};
        set1  = live1;
        set4  = {rx_boc_valid, rx_ais_ci_detect};
        next_st.sr1 = (st.sr1 & ~clr1) | set1;
        next_st.sr4 = (st.sr4 & ~clr4) | set4;

        // Interrupt: masked sources, silenced by the disable bit
        next_st.irq = (info1 || info4) &&
                      !st.ccr3[tac_pkg::IRQ_PIN_DISABLE_BIT];

        // Receive milliwatt substitution, pattern step advances once per frame
        next_st.bp_valid = rx_ch_valid;
        if (rx_ch_valid)
        begin
            if (rx_ch_num == 5'(tac_pkg::CHANNELS - 1))
                next_st.mw_idx = st.mw_idx + 3'h1;
            if (st.mw_sel[rx_ch_num])
                next_st.bp_data = tac_pkg::MILLIWATT_SEQ[6'(8 * (7 - int'(st.mw_idx))) +: 8];
            else
                next_st.bp_data = rx_ch_data;
        end

        // Transmit overhead insertion
        next_st.tx_valid     = tx_ch_valid;
        next_st.tx_ais_ci_on = st.fcc[tac_pkg::SEND_AIS_CI_BIT] &&
                               st.txc1[tac_pkg::SEND_BLUE_ALARM_BIT];
        next_st.tx_rai_ci_on = st.fcc[tac_pkg::SEND_RAI_CI_BIT] &&
                               st.txc2[tac_pkg::TX_ESF_BIT];
        if (tx_ch_valid)
        begin
            tb = tx_ch_data;
            // Global stuffing outranks both the enables and the clear marking
            stuff = (st.txc1[tac_pkg::STUFF_ALL_A_BIT] &&
                     st.txc2[tac_pkg::STUFF_ALL_B_BIT]) ||
                    (st.sig_en[tx_ch_num] && !st.clr_ch[tx_ch_num]);
            rob   = tx_rob_frame && st.sig_en[tx_ch_num] && !st.clr_ch[tx_ch_num];
            sidx  = 7'({tx_ch_num, tx_sig_sel});
            if (rob)
                tb[0] = st.sig[sidx];
            if (stuff && tb == 8'h00)
                tb[1] = 1'b1;
            if (st.txc1[tac_pkg::SEND_YELLOW_BIT] && !st.txc2[tac_pkg::TX_ESF_BIT])
                tb[6] = 1'b0;
            if (st.txc1[tac_pkg::SEND_BLUE_ALARM_BIT])
                tb = 8'hFF;
            next_st.tx_data = tb;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Everything clears at reset, so no source can interrupt until enabled
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    // Outputs straight from the state register
    assign prdata       = st.prdata;
    assign pready       = st.pready;
    assign pslverr      = st.pslverr;
    assign bp_valid     = st.bp_valid;
    assign bp_data      = st.bp_data;
    assign tx_valid     = st.tx_valid;
    assign tx_data      = st.tx_data;
    assign tx_ais_ci_on = st.tx_ais_ci_on;
    assign tx_rai_ci_on = st.tx_rai_ci_on;
    assign irq          = st.irq;
endmodule
`default_nettype wire

/* File: tac_alarm_ovh_chk.sv */
// Port-level assertions for the T1 alarm and overhead control block
`default_nettype none
module tac_alarm_ovh_chk #(parameter int BLUE_WIN = 64) (
    // Watched ports
    input wire logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr,
    input wire logic tx_ch_valid, tx_valid, rx_ch_valid, bp_valid, irq,
    input wire logic tx_ais_ci_on, tx_rai_ci_on
);
    // A committed write is the only cause that may move a transmit code flag
    logic wr;
    assign wr = psel && penable && pwrite && pready;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    AST_APB_PULSE: assert property (pready |=> !pready) else $error("pready held");
    AST_APB_ERR: assert property (pslverr |-> pready) else $error("lone pslverr");
    AST_RST_IRQ: assert property ($fell(sys_rst) |-> !irq)
        else $error("irq after reset");
    AST_TX_LAT: assert property (tx_ch_valid |=> tx_valid)
        else $error("tx byte lost");
    AST_TX_SRC: assert property (tx_valid |-> $past(tx_ch_valid))
        else $error("tx byte invented");
    AST_BP_LAT: assert property (rx_ch_valid |=> bp_valid)
        else $error("rx byte lost");
    AST_AIS_SRC: assert property ($changed(tx_ais_ci_on) |-> $past(wr) || $past(wr, 2))
        else $error("ais flag moved alone");
    AST_RAI_SRC: assert property ($changed(tx_rai_ci_on) |-> $past(wr) || $past(wr, 2))
        else $error("rai flag moved alone");
    cover property (pslverr);
    cover property ($rose(irq));
    cover property ($rose(tx_rai_ci_on));
endmodule
bind tac_alarm_ovh tac_alarm_ovh_chk #(.BLUE_WIN(BLUE_WIN)) u_chk (.*);
`default_nettype wire

/* File: tac_line_mdl.sv */
// Line-side model that delivers the received T1 bit stream
`default_nettype none
module tac_line_mdl (
    input  wire logic       ref_clk, sys_rst,
    input  wire logic [1:0] mode,
    output logic            rx_bit_valid, rx_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    // Mode 0 idle, 1 zeros, 2 ones; idle data toggles so no stale level is read
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            {rx_bit_valid, rx_bit} <= 2'b00;
        else
            {rx_bit_valid, rx_bit} <= {mode != 2'b00, mode == 2'b00 ? ~rx_bit : mode[1]};
    end
endmodule
`default_nettype wire

/* File: tac_alarm_ovh_tb.sv */
// Self-checking testbench for the T1 alarm and overhead control block
`default_nettype none
module tac_alarm_ovh_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sl;
    logic rx_bit_valid, rx_bit, rx_ais_ci_detect = 0, rx_boc_valid = 0, rx_frame_loss = 0;
    logic rx_fbit_valid = 0, rx_fbit_twelfth = 0, rx_fbit = 0, rx_fdl_valid = 0, rx_fdl_bit = 0;
    logic rx_ch_valid = 0, tx_ch_valid = 0, tx_rob_frame = 0, bp_valid, tx_valid, irq;
    logic tx_ais_ci_on, tx_rai_ci_on;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [5:0] rx_boc = '0;
    logic [4:0] rx_ch_num = '0, tx_ch_num = '0;
    logic [7:0] rx_ch_data = '0, tx_ch_data = '0, bp_data, tx_data;
    logic [1:0] tx_sig_sel = '0, mode = '0;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    // Small blue window keeps the run short
    tac_alarm_ovh #(.BLUE_WIN(64)) dut (.*);
    tac_line_mdl line (.*);
    always #50 ref_clk = ~ref_clk;
    // Hang guard, far above the several hundred cycles the sequence needs
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready rather than assuming the latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        {q, sl} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // One channel byte through the receive or transmit path
    task automatic io(input logic rx, input logic [4:0] ch, input logic [7:0] d, e);
        @(posedge ref_clk);
        {rx_ch_valid, tx_ch_valid, rx_ch_num, tx_ch_num} <= {rx, !rx, ch, ch};
        {rx_ch_data, tx_ch_data} <= {d, d};
        @(posedge ref_clk);
        {rx_ch_valid, tx_ch_valid} <= 2'b00;
        @(negedge ref_clk);
        chk(32'(rx ? bp_data : tx_data), 32'(e));
    endtask
    task automatic t_reset;
        apb(1'b0, 12'h004);
        chk(q, 32'h0);
        apb(1'b0, 12'h0FC);
        chk(32'(sl), 32'h1);
    endtask
    task automatic t_red;
        mode <= 2'b01;
        apb(1'b1, 12'h004, 32'h4);
        repeat (200) @(posedge ref_clk);
        chk(32'(irq), 32'h1);
        apb(1'b0, 12'h010);
        chk(q, 32'h1);
        apb(1'b1, 12'h018, 32'h40);
        repeat (3) @(posedge ref_clk);
        chk(32'(irq), 32'h0);
        apb(1'b1, 12'h018, 32'h0);
        mode <= 2'b10;
        repeat (260) @(posedge ref_clk);
        apb(1'b0, 12'h03C);
        chk(q & 32'h4, 32'h0);
    endtask
    task automatic t_tx;
        apb(1'b1, 12'h01C, 32'h8);
        apb(1'b1, 12'h020, 32'h1);
        io(1'b0, 5'h5, 8'h00, 8'h02);
        apb(1'b1, 12'h01C, 32'h9);
        apb(1'b1, 12'h028, 32'h1);
        io(1'b0, 5'h5, 8'h55, 8'hFF);
        chk(32'(tx_ais_ci_on), 32'h1);
        apb(1'b1, 12'h030, 32'h8);
        apb(1'b1, 12'h01C, 32'h2);
        apb(1'b1, 12'h020, 32'h0);
        io(1'b0, 5'h3, 8'hFF, 8'hBF);
        apb(1'b1, 12'h020, 32'h2);
        apb(1'b1, 12'h028, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk(32'(tx_rai_ci_on), 32'h1);
        // Robbed frame: channel 2 takes its bit, clear channel 3 must not
        apb(1'b1, 12'h02C, 32'hC);
        apb(1'b1, 12'h040, 32'h1100);
        tx_rob_frame <= 1'b1;
        io(1'b0, 5'h2, 8'h40, 8'h41);
        io(1'b0, 5'h3, 8'h00, 8'h00);
        io(1'b0, 5'h17, 8'h8B, 8'h8B);
    endtask
    task automatic t_mw;
        apb(1'b1, 12'h034, 32'h1);
        io(1'b1, 5'h0, 8'h77, 8'h1E);
        io(1'b1, 5'h1, 8'h77, 8'h77);
    endtask
    task automatic t_ais;
        @(posedge ref_clk);
        {rx_ais_ci_detect, rx_boc_valid, rx_boc, rx_frame_loss} <= {2'b11, 6'h1F, 1'b1};
        @(posedge ref_clk);
        {rx_ais_ci_detect, rx_boc_valid} <= 2'b00;
        apb(1'b0, 12'h008);
        chk(q, 32'h3);
        apb(1'b0, 12'h038);
        chk(q, 32'h1F);
        // Blue on the all-ones line is read beside the frame-loss level
        apb(1'b0, 12'h03C);
        chk(q, 32'h9);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_red();
        t_tx();
        t_mw();
        t_ais();
        summarize();
    end
endmodule
`default_nettype wire
